// file: logic/dtsc_pkg.sv
// constants, types and register map of the thread security checker
// assumes one 20 MHz clock, synchronous active-high reset, avalon-mm register access
//
// Overview of operation
// R1 - security setup taken from tie-offs after reset
// R2 - manager status shows manager security bit
// R3 - config register three shows event security bits
// R4 - config register four shows peripheral security bits
// R5 - channel security bit valid only outside stopped
// R6 - manager bit 0: secure manager, secure fetches
// R7 - secure manager start copies operand to channel
// R8 - secure manager waits and sends any event
// R9 - manager bit 1: non-secure manager, non-secure fetches
// R10 - non-secure secure-start: no-op, fault, faulting
// R11 - non-secure start operand 1 starts non-secure channel
// R12 - non-secure manager, secure event: no-op, fault
// R13 - channel bit 0: secure fetches, any data access
// R14 - secure channel waits events/peripherals regardless
// R15 - secure channel peripheral load/store always acknowledged
// R16 - permitted flush clears state, requests level resend
// R17 - channel bit 1: non-secure, non-secure fetches only
// R18 - non-secure channel, secure event: fault completing
// R19 - non-secure channel, secure peripheral: fault completing
// R20 - non-secure channel, non-secure peripheral proceeds normally
// R21 - non-secure control move requesting secure: fault
// R22 - manager fault: faulting at once, abort raised
// R23 - fault completing waits active transfers, no new
// R24 - secure thread fault cleared via secure terminate
// R25 - fault bits stay until terminate to stopped
package dtsc_pkg;

	localparam int NUM_CH = 8;
	localparam int NUM_EV = 32;
	localparam int NUM_PERIPH = 32;
	localparam int CH_W = 3;
	localparam int IDX_W = 5;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;

	// tie-off synchroniser settles before capture
	localparam logic [1:0] BOOT_SETTLE = 2'h2;

	// register byte addresses
	localparam logic [ADDR_W-1:0] ADDR_MGR_STATUS = 6'h00;
	localparam logic [ADDR_W-1:0] ADDR_CONFIG_THREE = 6'h04;
	localparam logic [ADDR_W-1:0] ADDR_CONFIG_FOUR = 6'h08;
	localparam logic [ADDR_W-1:0] ADDR_MGR_FAULT_STATUS = 6'h0c;
	localparam logic [ADDR_W-1:0] ADDR_MGR_FAULT_TYPE = 6'h10;
	localparam logic [ADDR_W-1:0] ADDR_CH_FAULT_STATUS = 6'h14;
	localparam logic [ADDR_W-1:0] ADDR_CH_SECURITY = 6'h18;
	localparam logic [ADDR_W-1:0] ADDR_CH_FAULT_TYPE = 6'h1c;
	localparam logic [ADDR_W-1:0] ADDR_TERMINATE = 6'h20;
	localparam logic [ADDR_W-1:0] ADDR_EVENT_RAW = 6'h24;
	localparam logic [ADDR_W-1:0] ADDR_PERIPH_PEND = 6'h28;

	// field positions
	localparam int MGR_NS_BIT = 0;
	localparam int MGR_FAULTING_BIT = 1;
	localparam int TERM_MGR_BIT = 0;
	localparam int TERM_CH_LSB = 8;
	localparam int CH_RUN_LSB = 8;
	localparam int CH_FT_STRIDE = 4;

	// manager fault type bits
	localparam int MFT_GO = 0;
	localparam int MFT_EVENT = 1;
	localparam int MFT_W = 2;

	// channel fault type bits
	localparam int CFT_EVENT = 0;
	localparam int CFT_PERIPH = 1;
	localparam int CFT_ACCESS = 2;
	localparam int CFT_W = 3;

	typedef enum logic [2:0] {
		OP_GO,
		OP_WAIT_EVENT,
		OP_SEND_EVENT,
		OP_WAIT_PERIPH,
		OP_PERIPH_LOAD,
		OP_PERIPH_STORE,
		OP_PERIPH_FLUSH,
		OP_MOVE_REG
	} dtsc_op_e;

	typedef enum logic [1:0] {
		CH_STOPPED,
		CH_EXECUTING,
		CH_FAULT_COMPLETING,
		CH_FAULTING
	} dtsc_ch_state_e;

endpackage

// file: logic/dtsc_chan.sv
// one channel thread: run state, security bit and fault record
// assumes start, fault and terminate are single-cycle pulses from the checker
module dtsc_chan
	import dtsc_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic start_ns,
	input wire logic fault,
	input wire logic [dtsc_pkg::CFT_W-1:0] fault_type,
	input wire logic terminate,
	input wire logic axi_busy,
	output dtsc_pkg::dtsc_ch_state_e state_q,
	output logic ns_q,
	output logic fault_status_q,
	output logic [dtsc_pkg::CFT_W-1:0] fault_type_q
);
	import dtsc_pkg::*;

	dtsc_ch_state_e state_d;

	// next run state; a fault in the terminate cycle wins
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			CH_STOPPED:
				if (start)
					state_d = CH_EXECUTING;
			CH_EXECUTING:
				if (fault)
					state_d = CH_FAULT_COMPLETING; // see R18 see R19 see R21
				else if (terminate)
					state_d = CH_STOPPED;
			CH_FAULT_COMPLETING:
				if (terminate)
					state_d = CH_STOPPED;
				else if (!axi_busy)
					state_d = CH_FAULTING; // see R23
			CH_FAULTING:
				if (terminate)
					state_d = CH_STOPPED;
			default:
				state_d = CH_STOPPED;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			state_q <= CH_STOPPED;
		else
			state_q <= state_d;
	end

	// security bit written only at start, so it means nothing while stopped
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			ns_q <= 1'b0;
		else if (start && state_q == CH_STOPPED)
			ns_q <= start_ns; // see R5 see R7 see R11
	end

	// fault record held until the thread is stopped again
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			fault_status_q <= 1'b0;
			fault_type_q <= '0;
		end
		else if (fault && state_q == CH_EXECUTING)
		begin
			fault_status_q <= 1'b1;
			fault_type_q <= fault_type_q | fault_type;
		end
		else if (state_d == CH_STOPPED && state_q != CH_STOPPED)
		begin
			fault_status_q <= 1'b0; // see R25
			fault_type_q <= '0;
		end
	end

endmodule

// file: logic/dtsc_top.sv
// security checker for the manager and channel threads of a dma controller
// assumes instruction decode outside offers one operation per cycle on op_*;
// software reaches the registers over avalon-mm with waitrequest
//
// Added by the designer: the placing of the registers and register access over Avalon-MM.
module dtsc_top
	import dtsc_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	// tie-offs, static but asynchronous to clk
	input wire logic boot_manager_ns,
	input wire logic [dtsc_pkg::NUM_EV-1:0] boot_event_ns,
	input wire logic [dtsc_pkg::NUM_PERIPH-1:0] boot_periph_ns,
	// peripheral request pins
	input wire logic [dtsc_pkg::NUM_PERIPH-1:0] periph_req,
	// per-channel outstanding transfer flag from the data path
	input wire logic [dtsc_pkg::NUM_CH-1:0] ch_axi_busy,
	// operation to check
	input wire logic op_valid,
	input wire logic op_mgr,
	input wire logic [dtsc_pkg::CH_W-1:0] op_chan,
	input dtsc_pkg::dtsc_op_e op_code,
	input wire logic [dtsc_pkg::IDX_W-1:0] op_index,
	input wire logic op_go_ns,
	input wire logic op_ccr_secure,
	// avalon-mm slave
	input wire logic [dtsc_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [dtsc_pkg::DATA_W-1:0] avs_writedata,
	output logic [dtsc_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	// check results, one-cycle pulses
	output logic res_valid,
	output logic res_refused,
	output logic res_nop,
	output logic res_go_start,
	output logic res_wait_event,
	output logic res_send_event,
	output logic res_wait_periph,
	output logic res_periph_ack,
	output logic res_flush_req,
	output logic [dtsc_pkg::IDX_W-1:0] res_index,
	output logic [dtsc_pkg::CH_W-1:0] res_chan,
	// thread security and state
	output logic mgr_fetch_ns,
	output logic [dtsc_pkg::NUM_CH-1:0] ch_fetch_ns,
	output logic [dtsc_pkg::NUM_CH-1:0] ch_secure_axi_ok,
	output logic [dtsc_pkg::NUM_CH-1:0] ch_axi_allow,
	output logic irq_abort
);
	import dtsc_pkg::*;

	// peripheral operations share the same security test
	function automatic logic is_periph_op(input dtsc_op_e op);
		is_periph_op = (op == OP_WAIT_PERIPH) || (op == OP_PERIPH_LOAD) ||
			(op == OP_PERIPH_STORE) || (op == OP_PERIPH_FLUSH);
	endfunction

	function automatic logic is_event_op(input dtsc_op_e op);
		is_event_op = (op == OP_WAIT_EVENT) || (op == OP_SEND_EVENT);
	endfunction

	// synchronisers for tie-offs and request pins
	logic boot_mgr_s1_q;
	logic boot_mgr_s2_q;
	logic [NUM_EV-1:0] boot_ev_s1_q;
	logic [NUM_EV-1:0] boot_ev_s2_q;
	logic [NUM_PERIPH-1:0] boot_per_s1_q;
	logic [NUM_PERIPH-1:0] boot_per_s2_q;
	logic [NUM_PERIPH-1:0] preq_s1_q;
	logic [NUM_PERIPH-1:0] preq_s2_q;

	// captured security configuration
	logic [1:0] boot_cnt_q;
	logic boot_done_q;
	logic mgr_ns_q;
	logic [NUM_EV-1:0] event_security_bits_q;
	logic [NUM_PERIPH-1:0] periph_security_bits_q;

	// manager fault record
	logic mgr_fault_q;
	logic [MFT_W-1:0] mgr_fault_type_q;

	// shared state
	logic [NUM_EV-1:0] event_raw_status_q;
	logic [NUM_PERIPH-1:0] periph_pend_q;

	// channel instances
	dtsc_ch_state_e ch_state [NUM_CH];
	logic [NUM_CH-1:0] ch_ns;
	logic [NUM_CH-1:0] ch_fstat;
	logic [CFT_W-1:0] ch_ftype [NUM_CH];
	logic [NUM_CH-1:0] ch_start;
	logic [NUM_CH-1:0] ch_fault;
	logic [NUM_CH-1:0] ch_term;
	logic [CFT_W-1:0] ch_fault_kind;

	// decision terms
	logic issuer_ok;
	logic issuer_ns;
	logic ev_ns;
	logic pr_ns;
	logic op_legal;
	logic op_viol;
	logic op_permit;
	logic go_ns_eff;

	// bus terms
	logic bus_req;
	logic wr_fire;
	logic term_mgr;
	logic [NUM_CH-1:0] term_ch;
	logic [DATA_W-1:0] rd_mux;
	logic [DATA_W-1:0] ft_pack;

	// two flops before anything reads the pins
	always_ff @(posedge clk)
	begin
		boot_mgr_s1_q <= boot_manager_ns;
		boot_mgr_s2_q <= boot_mgr_s1_q;
		boot_ev_s1_q <= boot_event_ns;
		boot_ev_s2_q <= boot_ev_s1_q;
		boot_per_s1_q <= boot_periph_ns;
		boot_per_s2_q <= boot_per_s1_q;
		preq_s1_q <= periph_req;
		preq_s2_q <= preq_s1_q;
	end

	// security taken once, after the synchronisers have filled since reset
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			boot_cnt_q <= '0;
			boot_done_q <= 1'b0;
			mgr_ns_q <= 1'b0;
			event_security_bits_q <= '0;
			periph_security_bits_q <= '0;
		end
		else if (!boot_done_q)
		begin
			if (boot_cnt_q == BOOT_SETTLE)
			begin
				boot_done_q <= 1'b1;
				mgr_ns_q <= boot_mgr_s2_q; // see R1
				event_security_bits_q <= boot_ev_s2_q;
				periph_security_bits_q <= boot_per_s2_q;
			end
			else
				boot_cnt_q <= boot_cnt_q + 2'h1;
		end
	end

	// security of the thread that issued the operation and of its target
	always_comb
	begin
		issuer_ok = boot_done_q &&
			(op_mgr ? !mgr_fault_q : (ch_state[op_chan] == CH_EXECUTING));
		issuer_ns = op_mgr ? mgr_ns_q : ch_ns[op_chan]; // see R6 see R9 see R13 see R17
		ev_ns = event_security_bits_q[op_index];
		pr_ns = periph_security_bits_q[op_index];
		// a secure manager keeps the operand, a non-secure one can only start non-secure
		go_ns_eff = mgr_ns_q ? 1'b1 : op_go_ns; // see R7 see R11
	end

	// legality and violation; a secure issuer never violates
	always_comb
	begin
		op_legal = 1'b0;
		op_viol = 1'b0;
		case (op_code)
			OP_GO:
			begin
				op_legal = op_mgr && (ch_state[op_chan] == CH_STOPPED);
				op_viol = issuer_ns && !op_go_ns; // see R10
			end
			OP_WAIT_EVENT, OP_SEND_EVENT:
			begin
				op_legal = 1'b1;
				op_viol = issuer_ns && !ev_ns; // see R8 see R12 see R14 see R18
			end
			OP_WAIT_PERIPH, OP_PERIPH_LOAD, OP_PERIPH_STORE, OP_PERIPH_FLUSH:
			begin
				op_legal = !op_mgr;
				op_viol = issuer_ns && !pr_ns; // see R14 see R15 see R19 see R20
			end
			OP_MOVE_REG:
			begin
				op_legal = !op_mgr;
				op_viol = issuer_ns && op_ccr_secure; // see R21
			end
			default:
			begin
				op_legal = 1'b0;
				op_viol = 1'b0;
			end
		endcase
		op_legal = op_legal && issuer_ok && op_valid;
		op_permit = op_legal && !op_viol;
	end

	// fault kind for the channel record
	always_comb
	begin
		ch_fault_kind = '0;
		if (is_event_op(op_code))
			ch_fault_kind[CFT_EVENT] = 1'b1;
		else if (is_periph_op(op_code))
			ch_fault_kind[CFT_PERIPH] = 1'b1;
		else
			ch_fault_kind[CFT_ACCESS] = 1'b1;
	end

	// per-channel pulses and the channel threads themselves
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++)
		begin : g_ch
			assign ch_start[gi] = op_permit && (op_code == OP_GO) &&
				(op_chan == CH_W'(gi));
			assign ch_fault[gi] = op_legal && op_viol && !op_mgr &&
				(op_chan == CH_W'(gi));
			assign ch_term[gi] = term_ch[gi];
			assign ft_pack[gi*CH_FT_STRIDE +: CH_FT_STRIDE] = {1'b0, ch_ftype[gi]};
			dtsc_chan u_chan (
				.clk(clk),
				.sys_rst(sys_rst),
				.start(ch_start[gi]),
				.start_ns(go_ns_eff),
				.fault(ch_fault[gi]),
				.fault_type(ch_fault_kind),
				.terminate(ch_term[gi]),
				.axi_busy(ch_axi_busy[gi]),
				.state_q(ch_state[gi]),
				.ns_q(ch_ns[gi]),
				.fault_status_q(ch_fstat[gi]),
				.fault_type_q(ch_ftype[gi])
			);
		end
	endgenerate

	// check results one cycle after the operation is offered
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			res_valid <= 1'b0;
			res_refused <= 1'b0;
			res_nop <= 1'b0;
			res_go_start <= 1'b0;
			res_wait_event <= 1'b0;
			res_send_event <= 1'b0;
			res_wait_periph <= 1'b0;
			res_periph_ack <= 1'b0;
			res_flush_req <= 1'b0;
			res_index <= '0;
			res_chan <= '0;
		end
		else
		begin
			res_valid <= op_valid;
			res_refused <= op_valid && !op_legal;
			res_nop <= op_legal && op_viol; // see R10 see R12 see R18 see R19 see R21
			res_go_start <= op_permit && (op_code == OP_GO);
			res_wait_event <= op_permit && (op_code == OP_WAIT_EVENT);
			res_send_event <= op_permit && (op_code == OP_SEND_EVENT);
			res_wait_periph <= op_permit && (op_code == OP_WAIT_PERIPH);
			res_periph_ack <= op_permit &&
				(op_code == OP_PERIPH_LOAD || op_code == OP_PERIPH_STORE); // see R15 see R20
			res_flush_req <= op_permit && (op_code == OP_PERIPH_FLUSH); // see R16
			res_index <= op_index;
			res_chan <= op_chan;
		end
	end

	// manager goes straight to faulting; record held until terminated
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			mgr_fault_q <= 1'b0;
			mgr_fault_type_q <= '0;
		end
		else if (op_legal && op_viol && op_mgr)
		begin
			mgr_fault_q <= 1'b1; // see R22
			if (op_code == OP_GO)
				mgr_fault_type_q[MFT_GO] <= 1'b1; // see R10
			else
				mgr_fault_type_q[MFT_EVENT] <= 1'b1; // see R12
		end
		else if (term_mgr)
		begin
			mgr_fault_q <= 1'b0; // see R25
			mgr_fault_type_q <= '0;
		end
	end

	// raw event status: send sets, software write-one clears, set wins
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			event_raw_status_q <= '0;
		else
		begin
			for (int i = 0; i < NUM_EV; i++)
			begin
				if (op_permit && op_code == OP_SEND_EVENT && op_index == IDX_W'(i))
					event_raw_status_q[i] <= 1'b1; // see R8
				else if (wr_fire && avs_address == ADDR_EVENT_RAW && avs_writedata[i])
					event_raw_status_q[i] <= 1'b0;
			end
		end
	end

	// peripheral request state; a permitted flush forgets it, a new request wins
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			periph_pend_q <= '0;
		else
		begin
			for (int i = 0; i < NUM_PERIPH; i++)
			begin
				if (preq_s2_q[i])
					periph_pend_q[i] <= 1'b1;
				else if (op_permit && op_code == OP_PERIPH_FLUSH && op_index == IDX_W'(i))
					periph_pend_q[i] <= 1'b0; // see R16
			end
		end
	end

	// thread security and access permission outputs
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ch_secure_axi_ok <= '0;
			ch_axi_allow <= '0;
			irq_abort <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				ch_axi_allow[i] <= (ch_state[i] == CH_EXECUTING); // see R23
				ch_secure_axi_ok[i] <= (ch_state[i] == CH_EXECUTING) && !ch_ns[i]; // see R13
			end
			irq_abort <= mgr_fault_q || (|ch_fstat); // see R22
		end
	end

	// fetch security follows the thread bits directly
	assign mgr_fetch_ns = mgr_ns_q; // see R6 see R9
	assign ch_fetch_ns = ch_ns; // see R13 see R17

	// bus: one wait cycle, then the access completes with waitrequest low
	assign bus_req = avs_read || avs_write;
	assign wr_fire = avs_write && !avs_waitrequest;
	assign term_mgr = wr_fire && avs_address == ADDR_TERMINATE &&
		avs_writedata[TERM_MGR_BIT]; // see R24
	assign term_ch = wr_fire && avs_address == ADDR_TERMINATE ?
		avs_writedata[TERM_CH_LSB +: NUM_CH] : '0;

	// read mux; unmapped addresses read zero
	always_comb
	begin
		rd_mux = '0;
		case (avs_address)
			ADDR_MGR_STATUS:
			begin
				rd_mux[MGR_NS_BIT] = mgr_ns_q; // see R2
				rd_mux[MGR_FAULTING_BIT] = mgr_fault_q;
			end
			ADDR_CONFIG_THREE:
				rd_mux[NUM_EV-1:0] = event_security_bits_q; // see R3
			ADDR_CONFIG_FOUR:
				rd_mux[NUM_PERIPH-1:0] = periph_security_bits_q; // see R4
			ADDR_MGR_FAULT_STATUS:
				rd_mux[0] = mgr_fault_q;
			ADDR_MGR_FAULT_TYPE:
				rd_mux[MFT_W-1:0] = mgr_fault_type_q;
			ADDR_CH_FAULT_STATUS:
				rd_mux[NUM_CH-1:0] = ch_fstat;
			ADDR_CH_SECURITY:
				for (int i = 0; i < NUM_CH; i++)
				begin
					rd_mux[i] = ch_ns[i] && (ch_state[i] != CH_STOPPED); // see R5
					rd_mux[CH_RUN_LSB + i] = (ch_state[i] != CH_STOPPED);
				end
			ADDR_CH_FAULT_TYPE:
				rd_mux = ft_pack;
			ADDR_EVENT_RAW:
				rd_mux[NUM_EV-1:0] = event_raw_status_q;
			ADDR_PERIPH_PEND:
				rd_mux[NUM_PERIPH-1:0] = periph_pend_q;
			default:
				rd_mux = '0;
		endcase
	end

	// waitrequest drops for one cycle per access, read data captured with it
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= '0;
		end
		else if (bus_req && avs_waitrequest)
		begin
			avs_waitrequest <= 1'b0;
			avs_readdata <= rd_mux;
		end
		else
			avs_waitrequest <= 1'b1;
	end

endmodule

// file: tb/dtsc_checker.sv
// port assertions for the thread security checker
// assumes binding onto dtsc_top, one clock, tie-offs static between resets
module dtsc_checker
	import dtsc_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic boot_manager_ns,
	input wire logic [dtsc_pkg::NUM_PERIPH-1:0] boot_periph_ns,
	input wire logic op_valid,
	input wire logic op_mgr,
	input wire logic [dtsc_pkg::CH_W-1:0] op_chan,
	input dtsc_pkg::dtsc_op_e op_code,
	input wire logic [dtsc_pkg::IDX_W-1:0] op_index,
	input wire logic op_go_ns,
	input wire logic [dtsc_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_write,
	input wire logic res_valid,
	input wire logic res_refused,
	input wire logic res_nop,
	input wire logic res_go_start,
	input wire logic res_flush_req,
	input wire logic [dtsc_pkg::CH_W-1:0] res_chan,
	input wire logic mgr_fetch_ns,
	input wire logic [dtsc_pkg::NUM_CH-1:0] ch_fetch_ns,
	input wire logic [dtsc_pkg::NUM_CH-1:0] ch_secure_axi_ok,
	input wire logic [dtsc_pkg::NUM_CH-1:0] ch_axi_allow,
	input wire logic irq_abort
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [2:0] up_cnt_q;
	logic ch_ns_run;
	logic term_wr;
	// edges since reset release, saturating; capture is done by edge 3
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			up_cnt_q <= 3'h0;
		else if (up_cnt_q != 3'h7)
			up_cnt_q <= up_cnt_q + 3'h1;
	end
	// issuing channel runs non-secure
	assign ch_ns_run = ch_axi_allow[op_chan] & ch_fetch_ns[op_chan];
	assign term_wr = avs_write && (avs_address == ADDR_TERMINATE);
	property p_boot_capture;
		up_cnt_q >= 3'h5 |-> mgr_fetch_ns == boot_manager_ns;
	endproperty
	a_boot_capture: assert property (p_boot_capture) else $error("manager bit differs from tie-off");
	property p_secure_go;
		op_valid && op_mgr && op_code == OP_GO && !mgr_fetch_ns |=> res_valid && !res_nop;
	endproperty
	a_secure_go: assert property (p_secure_go) else $error("secure start faulted");
	property p_ns_go;
		op_valid && op_mgr && op_code == OP_GO && mgr_fetch_ns && !op_go_ns
			|=> !res_go_start && (res_nop || res_refused);
	endproperty
	a_ns_go: assert property (p_ns_go) else $error("secure start by non-secure manager");
	property p_secure_mgr_event;
		op_valid && op_mgr && !mgr_fetch_ns && op_code inside {OP_WAIT_EVENT, OP_SEND_EVENT}
			|=> !res_nop;
	endproperty
	a_secure_mgr_event: assert property (p_secure_mgr_event) else $error("secure manager event fault");
	property p_secure_ch;
		op_valid && !op_mgr && ch_secure_axi_ok[op_chan] |=> !res_nop;
	endproperty
	a_secure_ch: assert property (p_secure_ch) else $error("secure channel faulted");
	property p_ns_flush;
		op_valid && !op_mgr && ch_ns_run && op_code == OP_PERIPH_FLUSH
			|=> boot_periph_ns[$past(op_index)] ? res_flush_req : res_nop && !res_flush_req;
	endproperty
	a_ns_flush: assert property (p_ns_flush) else $error("flush check wrong");
	property p_fault_axi;
		res_nop && !$past(op_mgr) |-> ##2 !ch_axi_allow[$past(res_chan, 2)];
	endproperty
	a_fault_axi: assert property (p_fault_axi) else $error("faulted channel still allowed");
	property p_mgr_abort;
		res_nop && $past(op_mgr) |-> ##[1:2] irq_abort;
	endproperty
	a_mgr_abort: assert property (p_mgr_abort) else $error("no abort after manager fault");
	property p_fault_holds;
		$fell(irq_abort) |-> $past(term_wr, 1) || $past(term_wr, 2);
	endproperty
	a_fault_holds: assert property (p_fault_holds) else $error("abort dropped without terminate");
	property p_ch_sec;
		(ch_secure_axi_ok & ch_fetch_ns) == '0;
	endproperty
	a_ch_sec: assert property (p_ch_sec) else $error("non-secure channel secure access");
endmodule
bind dtsc_top dtsc_checker i_checker (.clk, .sys_rst, .boot_manager_ns, .boot_periph_ns,
	.op_valid, .op_mgr, .op_chan, .op_code, .op_index, .op_go_ns, .avs_address, .avs_write,
	.res_valid, .res_refused, .res_nop, .res_go_start, .res_flush_req, .res_chan, .mgr_fetch_ns,
	.ch_fetch_ns, .ch_secure_axi_ok, .ch_axi_allow, .irq_abort);

// file: tb/testbench.sv
// self-checking bench for the thread security checker
// assumes avalon-mm access of 2 cycles and result pulses one edge after an op
module testbench;
	import dtsc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] RF = 8'h80, NP = 8'h40, GS = 8'h20, WE = 8'h10;
	localparam logic [7:0] SE = 8'h08, WP = 8'h04, PA = 8'h02, FL = 8'h01;
	logic clk = 1'b0, sys_rst = 1'b1, boot_manager_ns = 1'b0, op_valid = 1'b0, op_mgr = 1'b0;
	logic [31:0] boot_event_ns = '0, boot_periph_ns = '0, periph_req = '0, avs_writedata = '0;
	logic [7:0] ch_axi_busy = '0;
	logic [2:0] op_chan = '0, res_chan;
	dtsc_op_e op_code = OP_GO;
	logic [4:0] op_index = '0, res_index;
	logic op_go_ns = 1'b0, op_ccr_secure = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic [5:0] avs_address = '0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, res_valid, res_refused, res_nop, res_go_start, res_wait_event;
	logic res_send_event, res_wait_periph, res_periph_ack, res_flush_req, mgr_fetch_ns, irq_abort;
	logic [7:0] ch_fetch_ns, ch_secure_axi_ok, ch_axi_allow;
	int num_errors = 0, tests_run = 0;
	dtsc_op_e fc [7] = '{OP_WAIT_EVENT, OP_SEND_EVENT, OP_WAIT_PERIPH, OP_PERIPH_LOAD,
		OP_PERIPH_STORE, OP_PERIPH_FLUSH, OP_MOVE_REG};
	logic [4:0] fi [7] = '{5'h14, 5'h14, 5'h08, 5'h08, 5'h08, 5'h08, 5'h00};
	logic [31:0] ft [7] = '{32'h10, 32'h10, 32'h20, 32'h20, 32'h20, 32'h20, 32'h40};
	dtsc_top i_dut (.clk, .sys_rst, .boot_manager_ns, .boot_event_ns, .boot_periph_ns,
		.periph_req, .ch_axi_busy, .op_valid, .op_mgr, .op_chan, .op_code, .op_index, .op_go_ns,
		.op_ccr_secure, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .res_valid, .res_refused, .res_nop, .res_go_start, .res_wait_event,
		.res_send_event, .res_wait_periph, .res_periph_ack, .res_flush_req, .res_index,
		.res_chan, .mgr_fetch_ns, .ch_fetch_ns, .ch_secure_axi_ok, .ch_axi_allow, .irq_abort);
	// free-running 20 MHz clock
	initial
	begin
		forever #25 clk = ~clk;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask
	task automatic stop_test;
		$display("mismatches %0d of %0d checks", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// tie-offs only change while reset is held
	task automatic apply_reset(input logic m, input logic [31:0] ev, input logic [31:0] pn);
		@(posedge clk);
		sys_rst <= 1'b1;
		boot_manager_ns <= m;
		boot_event_ns <= ev;
		boot_periph_ns <= pn;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (6) @(posedge clk);
	endtask
	// one bus access; request stands until waitrequest is sampled low at a rising edge
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
		input logic [31:0] e);
		logic [31:0] v;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		do
			@(posedge clk);
		while (avs_waitrequest !== 1'b0);
		v = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (!wr)
			check(v, e);
	endtask
	// one op, then the result pulses compared one edge later
	task automatic op(input logic m, input logic [2:0] c, input dtsc_op_e k,
		input logic [4:0] i, input logic g, input logic [7:0] e);
		@(posedge clk);
		op_valid <= 1'b1;
		op_mgr <= m;
		op_chan <= c;
		op_code <= k;
		op_index <= i;
		op_go_ns <= g;
		op_ccr_secure <= g;
		@(posedge clk);
		op_valid <= 1'b0;
		#1;
		check({24'h0, res_refused, res_nop, res_go_start, res_wait_event, res_send_event,
			res_wait_periph, res_periph_ack, res_flush_req}, {24'h0, e});
		check({24'h0, res_chan, res_index}, {24'h0, c, i});
	endtask
	// hang guard, well beyond the expected run
	initial
	begin
		repeat (6000) @(posedge clk);
		num_errors++;
		stop_test();
	end
	initial
	begin
		apply_reset(1'b0, 32'h0000ffff, 32'h00ff00ff);
		bus(1'b0, ADDR_MGR_STATUS, '0, 32'h0);
		periph_req <= 32'h00000100;
		bus(1'b0, ADDR_CONFIG_THREE, '0, 32'h0000ffff);
		periph_req <= '0;
		bus(1'b0, ADDR_CONFIG_FOUR, '0, 32'h00ff00ff);
		bus(1'b0, 6'h3c, '0, 32'h0);
		$display("register test done");
		op(1'b1, 3'h0, OP_GO, 5'h0, 1'b0, GS);
		op(1'b1, 3'h1, OP_GO, 5'h0, 1'b1, GS);
		bus(1'b0, ADDR_CH_SECURITY, '0, 32'h0302);
		op(1'b1, 3'h0, OP_SEND_EVENT, 5'h14, 1'b0, SE);
		bus(1'b0, ADDR_EVENT_RAW, '0, 32'h00100000);
		op(1'b1, 3'h0, OP_WAIT_EVENT, 5'h14, 1'b0, WE);
		op(1'b0, 3'h0, OP_SEND_EVENT, 5'h14, 1'b0, SE);
		op(1'b0, 3'h0, OP_WAIT_PERIPH, 5'h08, 1'b0, WP);
		op(1'b0, 3'h0, OP_PERIPH_LOAD, 5'h08, 1'b0, PA);
		bus(1'b0, ADDR_PERIPH_PEND, '0, 32'h00000100);
		op(1'b0, 3'h0, OP_PERIPH_FLUSH, 5'h08, 1'b0, FL);
		bus(1'b0, ADDR_PERIPH_PEND, '0, 32'h0);
		op(1'b0, 3'h0, OP_MOVE_REG, 5'h0, 1'b1, 8'h00);
		op(1'b0, 3'h1, OP_WAIT_PERIPH, 5'h0, 1'b0, WP);
		op(1'b0, 3'h1, OP_PERIPH_STORE, 5'h0, 1'b0, PA);
		op(1'b0, 3'h1, OP_PERIPH_FLUSH, 5'h0, 1'b0, FL);
		$display("permitted op test done");
		@(posedge clk);
		ch_axi_busy <= 8'h02;
		for (int k = 0; k < 7; k++)
		begin
			op(1'b0, 3'h1, fc[k], fi[k], 1'b1, NP);
			op(1'b0, 3'h1, OP_SEND_EVENT, 5'h3, 1'b0, RF);
			bus(1'b0, ADDR_CH_FAULT_STATUS, '0, 32'h2);
			bus(1'b0, ADDR_CH_FAULT_TYPE, '0, ft[k]);
			check({24'h0, ch_axi_allow}, 32'h01);
			check({31'h0, irq_abort}, 32'h1);
			bus(1'b1, ADDR_TERMINATE, 32'h200, '0);
			bus(1'b0, ADDR_CH_FAULT_STATUS, '0, 32'h0);
			op(1'b1, 3'h1, OP_GO, 5'h0, 1'b1, GS);
		end
		$display("channel fault test done");
		apply_reset(1'b1, 32'h0000ffff, 32'h00ff00ff);
		bus(1'b0, ADDR_MGR_STATUS, '0, 32'h1);
		op(1'b1, 3'h2, OP_GO, 5'h0, 1'b1, GS);
		bus(1'b0, ADDR_CH_SECURITY, '0, 32'h0404);
		op(1'b1, 3'h0, OP_SEND_EVENT, 5'h3, 1'b0, SE);
		op(1'b1, 3'h0, OP_WAIT_EVENT, 5'h3, 1'b0, WE);
		op(1'b1, 3'h3, OP_GO, 5'h0, 1'b0, NP);
		bus(1'b0, ADDR_CH_SECURITY, '0, 32'h0404);
		bus(1'b0, ADDR_MGR_FAULT_TYPE, '0, 32'h1);
		bus(1'b0, ADDR_MGR_STATUS, '0, 32'h3);
		check({31'h0, irq_abort}, 32'h1);
		op(1'b1, 3'h0, OP_SEND_EVENT, 5'h3, 1'b0, RF);
		bus(1'b1, ADDR_TERMINATE, 32'h1, '0);
		bus(1'b0, ADDR_MGR_FAULT_STATUS, '0, 32'h0);
		op(1'b1, 3'h0, OP_WAIT_EVENT, 5'h14, 1'b0, NP);
		bus(1'b0, ADDR_MGR_FAULT_TYPE, '0, 32'h2);
		bus(1'b1, ADDR_TERMINATE, 32'h1, '0);
		op(1'b1, 3'h0, OP_SEND_EVENT, 5'h14, 1'b0, NP);
		bus(1'b0, ADDR_MGR_FAULT_STATUS, '0, 32'h1);
		$display("manager test done");
		stop_test();
	end
endmodule
